// [test/gfs_fix_status_asserts.sv]
`timescale 1ns/1ps
// Status output checker, sized for the short test parameters
module gfs_fix_status_asserts (
  // Clock and reset
  input wire clk_sys,
  input wire reset,
  input wire clk_en,
  // Navigation status
  input wire lock_3d,
  input wire [3:0] update_hz,
  // Watched outputs
  input wire time_mark_out,
  input wire mark_led,
  input wire fix_status_n,
  input wire fix_led_n,
  input wire aug_enable,
  input wire factory_default_req,
  input wire cmd_valid
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Mark high eight cycles, then low three cycles later; fixed because repetition counts are literal
  sequence mark_hold_s;
    time_mark_out [*8] ##3 !time_mark_out;
  endsequence
  mark_width_a: assert property ($rose(time_mark_out) |-> mark_hold_s)
    else $error("mark width wrong");
  mark_unlocked_a: assert property (!lock_3d |=> !time_mark_out)
    else $error("mark without lock");
  led_mirror_a: assert property (mark_led == time_mark_out)
    else $error("mark led differs");
  fix_held_a: assert property (lock_3d |=> !fix_status_n)
    else $error("fix status not low");
  blink_pair_a: assert property (!lock_3d [*2] |-> fix_led_n == fix_status_n)
    else $error("fix led not with status");
  led_dark_a: assert property (lock_3d |=> fix_led_n)
    else $error("fix led lit when locked");
  aug_rate_a: assert property (1 |=> aug_enable == ($past(update_hz) <= 4'h5))
    else $error("augmentation rate gate wrong");
  factory_sticky_a: assert property (factory_default_req |=> factory_default_req)
    else $error("factory request dropped");
  cmd_pulse_a: assert property (cmd_valid |=> !cmd_valid)
    else $error("command strobe too long");
  // A low enable must freeze the time mark, fix status and factory request outputs
  freeze_hold_a: assert property (!clk_en |=> $stable(time_mark_out) && $stable(fix_status_n)
    && $stable(factory_default_req))
    else $error("output moved while frozen");
endmodule // gfs_fix_status_asserts

// [test/gfs_fix_status_test.sv]
`timescale 1ns/1ps
`define CHK(a,b) begin comparisons++; if ((a) !== (b)) begin err_count++; $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module gfs_fix_status_test;
  logic clk_sys = 0, reset = 1, lock_3d = 0, nmea_valid = 0, correction_in = 0, backup_pin = 1;
  logic clk_en = 1;
  logic [3:0] update_hz = 4'h1;
  logic [7:0] nmea_data = 8'h00;
  wire nmea_ready, serial_rx, serial_tx, time_mark_out, mark_led, fix_status_n, fix_led_n;
  wire aug_enable, factory_default_req, cmd_valid;
  wire [7:0] cmd_data;
  int err_count = 0, comparisons = 0, n, k;
  always #5 clk_sys = ~clk_sys;
  // Short counts keep the run brief
  gfs_fix_status #(.EPOCH_CYC(100), .MARK_CYC(10), .BLINK_HALF_CYC(50), .FACTORY_CYC(300),
    .BIT_CYC(8)) dut_u (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .lock_3d(lock_3d),
    .update_hz(update_hz), .nmea_data(nmea_data), .nmea_valid(nmea_valid),
    .nmea_ready(nmea_ready), .serial_rx(serial_rx), .serial_tx(serial_tx),
    .correction_in(correction_in), .backup_pin(backup_pin), .time_mark_out(time_mark_out),
    .mark_led(mark_led), .fix_status_n(fix_status_n), .fix_led_n(fix_led_n),
    .aug_enable(aug_enable), .factory_default_req(factory_default_req), .cmd_data(cmd_data),
    .cmd_valid(cmd_valid));
  gfs_host_model host_u (.clk_sys(clk_sys), .serial_tx(serial_tx),
    .serial_rx(serial_rx));
  task tally_and_finish;
    if (err_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task tick(int c);
    repeat (c) @(negedge clk_sys);
  endtask
  // A wait that runs too long ends the run
  task guard(int c);
    if (c > 400) begin
      err_count++;
      tally_and_finish;
    end
  endtask
  function logic pick(int s);
    return s ? time_mark_out : fix_status_n;
  endfunction
  // Cycles the chosen output stays at v
  task run_len(int s, logic v);
    for (n = 0; pick(s) === v; n++) begin
      guard(n);
      tick(1);
    end
  endtask
  task t_search;
    run_len(0, 1);
    run_len(0, 0);
    `CHK(n, 50)
    run_len(0, 1);
    `CHK(n, 50)
  endtask
  task t_mark;
    lock_3d = 1;
    tick(1);
    `CHK(fix_status_n, 1'b0)
    `CHK(fix_led_n, 1'b1)
    run_len(1, 0);
    `CHK(mark_led, 1'b1)
    run_len(1, 1);
    `CHK(n, 10)
    run_len(1, 0);
    `CHK(n, 90)
    // Lock is dropped only after a whole pulse, so no pulse is cut short
    run_len(1, 1);
    `CHK(n, 10)
    `CHK(mark_led, 1'b0)
    lock_3d = 0;
    tick(1);
    `CHK(fix_status_n, 1'b1)
  endtask
  // Two sentence bytes, the second offered once the host has received the first
  task t_send;
    for (int i = 0; i < 2; i++) begin
      nmea_data = i ? 8'h81 : 8'h24;
      nmea_valid = 1;
      for (k = 0; nmea_ready !== 1'b1; k++) begin
        guard(k);
        tick(1);
      end
      tick(1);
      nmea_valid = 0;
      for (k = 0; host_u.rx_count != i + 1; k++) begin
        guard(k);
        tick(1);
      end
      `CHK(host_u.rx_byte, nmea_data)
    end
  endtask
  // Command byte while the correction input chatters
  task t_cmd;
    fork
      host_u.send_byte(8'hc3);
      for (k = 0; cmd_valid !== 1'b1; k++) begin
        correction_in = ~correction_in;
        guard(k);
        tick(1);
      end
    join
    `CHK(cmd_data, 8'hc3)
  endtask
  // Rates on both sides of the augmentation limit
  task t_aug;
    logic [3:0] rates [4];
    rates = '{4'h0, 4'h5, 4'h6, 4'hf};
    foreach (rates[i]) begin
      update_hz = rates[i];
      tick(2);
      `CHK(aug_enable, rates[i] <= 4'h5)
    end
  endtask
  task t_factory;
    backup_pin = 0;
    tick(290);
    backup_pin = 1;
    tick(2);
    `CHK(factory_default_req, 1'b0)
    // A frozen block must not count the grounded pin
    backup_pin = 0;
    clk_en = 0;
    tick(350);
    `CHK(factory_default_req, 1'b0)
    clk_en = 1;
    tick(310);
    backup_pin = 1;
    tick(5);
    `CHK(factory_default_req, 1'b1)
    reset = 1;
    tick(4);
    reset = 0;
    tick(1);
    `CHK(factory_default_req, 1'b0)
    `CHK(fix_status_n, 1'b1)
    `CHK(time_mark_out, 1'b0)
  endtask
  initial begin
    tick(4);
    reset = 0;
    tick(2);
    t_search;
    t_mark;
    t_send;
    t_cmd;
    t_aug;
    t_factory;
    tally_and_finish;
  end
endmodule // gfs_fix_status_test
bind gfs_fix_status gfs_fix_status_asserts chk_u (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en),
  .lock_3d(lock_3d), .update_hz(update_hz), .time_mark_out(time_mark_out),
  .mark_led(mark_led), .fix_status_n(fix_status_n), .fix_led_n(fix_led_n),
  .aug_enable(aug_enable), .factory_default_req(factory_default_req), .cmd_valid(cmd_valid));

// [test/gfs_host_model.sv]
`timescale 1ns/1ps
// Host end of the serial pair
module gfs_host_model #(parameter int BIT_CYC = 8) (
  // Clock
  input wire clk_sys,
  // Serial pair
  input wire serial_tx,
  output logic serial_rx
);
  logic [7:0] rx_byte, sh; // Last sentence byte, shifter
  int rx_count = 0; // Good frames seen
  initial serial_rx = 1'b1;
  // Command frame: start low, LSB first, stop high
  task send_byte(input logic [7:0] b);
    @(posedge clk_sys);
    for (int i = 0; i < 10; i++) begin
      serial_rx <= {1'b1, b, 1'b0} >> i;
      repeat (BIT_CYC) @(posedge clk_sys);
    end
  endtask
  // Decode mid-bit; a low stop bit drops the frame
  always begin
    @(negedge serial_tx);
    repeat (BIT_CYC / 2) @(posedge clk_sys);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge clk_sys);
      sh[i] = serial_tx;
    end
    repeat (BIT_CYC) @(posedge clk_sys);
    if (serial_tx) begin
      rx_byte = sh;
      rx_count++;
    end
  end
endmodule // gfs_host_model

// [verilog/gfs_defines.vh]
`ifndef GFS_DEFINES_VH
`define GFS_DEFINES_VH
// Clock rate
`define GFS_CLK_HZ 100000000
// Time mark: one-second epoch and 100 ms high time
`define GFS_EPOCH_MS 1000
`define GFS_MARK_MS 100
`define GFS_EPOCH_CYC ((`GFS_CLK_HZ / 1000) * `GFS_EPOCH_MS)
`define GFS_MARK_CYC ((`GFS_CLK_HZ / 1000) * `GFS_MARK_MS)
// Searching blink: 0.5 Hz, one second each half
`define GFS_BLINK_HALF_MS 1000
`define GFS_BLINK_HALF_CYC ((`GFS_CLK_HZ / 1000) * `GFS_BLINK_HALF_MS)
// Factory-default request: backup pin low for 10 s
`define GFS_FACTORY_S 10
`define GFS_FACTORY_CYC (`GFS_CLK_HZ * `GFS_FACTORY_S)
// Serial link 9600 bit/s, 8N1
`define GFS_BAUD 9600
// Bit time in clock cycles, clock over baud rounded down; sized to fit the 16-bit counters
`define GFS_BIT_CYC 16'h28b0
// Augmentation allowed up to 5 Hz update rate
`define GFS_AUG_MAX_HZ 5
`endif

// [verilog/gfs_fix_status.v]
`timescale 1ns/1ps
`include "gfs_defines.vh"
// Behaviour
// - 100 ms time mark each second when locked
// - Blue LED mirrors time mark exactly
// - Fix status held steadily low when locked
// - Blink fix status and LED at 0.5 Hz
// - Fix LED dark once 3D fix held
// - Send NMEA sentences on serial transmit line
// - Ignore differential correction input entirely
// - Augmentation only at 5 Hz or slower
// - Backup pin doubles as factory-default request
// - Ten-second low requests defaults on next power
module gfs_fix_status #(
  parameter [31:0] EPOCH_CYC = `GFS_EPOCH_CYC,
  parameter [31:0] MARK_CYC = `GFS_MARK_CYC,
  parameter [31:0] BLINK_HALF_CYC = `GFS_BLINK_HALF_CYC,
  parameter [31:0] FACTORY_CYC = `GFS_FACTORY_CYC,
  parameter [15:0] BIT_CYC = `GFS_BIT_CYC
) (
  // Clock, reset, enable
  clk_sys,
  reset,
  clk_en,
  // Navigation engine status
  lock_3d,
  update_hz,
  // Sentence bytes from navigation engine
  nmea_data,
  nmea_valid,
  nmea_ready,
  // Serial pins
  serial_rx,
  serial_tx,
  correction_in,
  // Backup battery pin, sensed level
  backup_pin,
  // Outputs
  time_mark_out,
  mark_led,
  fix_status_n,
  fix_led_n,
  aug_enable,
  factory_default_req,
  cmd_data,
  cmd_valid
);
  input wire clk_sys;
  input wire reset;
  input wire clk_en;
  input wire lock_3d;
  input wire [3:0] update_hz;
  input wire [7:0] nmea_data;
  input wire nmea_valid;
  output wire nmea_ready;
  input wire serial_rx;
  output wire serial_tx;
  // Correction stream is not enabled in this build, so it is never read
  input wire correction_in;
  input wire backup_pin;
  output reg time_mark_out;
  output reg mark_led;
  output reg fix_status_n;
  output reg fix_led_n;
  output reg aug_enable;
  output reg factory_default_req;
  output reg [7:0] cmd_data;
  output reg cmd_valid;

  // Fix indicator states, one-hot
  localparam [1:0] ST_SEARCH = 2'b01;
  localparam [1:0] ST_LOCKED = 2'b10;

  reg [31:0] epoch_q; // One-second epoch counter
  reg [31:0] blink_q; // Half-period counter of the search blink
  reg [31:0] bat_q; // Low time of the backup pin
  reg [1:0] state_q; // Fix indicator state
  reg lock_q; // Lock as seen last cycle
  reg blink_lvl_q; // Current blink level

  // Receive side
  reg [15:0] rx_baud_q;
  reg [3:0] rx_bit_q;
  reg [7:0] rx_shift_q;
  reg rx_busy_q;

  // Epoch counter runs free, so the first mark rises at the next epoch wrap after lock
  always @(posedge clk_sys) begin
    if (reset) begin
      epoch_q <= 32'h0000_0000;
      lock_q <= 1'b0;
      time_mark_out <= 1'b0;
      mark_led <= 1'b0;
    end else if (clk_en) begin
      lock_q <= lock_3d;
      if (epoch_q == EPOCH_CYC - 32'h0000_0001) begin
        epoch_q <= 32'h0000_0000;
      end else begin
        epoch_q <= epoch_q + 32'h0000_0001;
      end
      // Mark high for the first 100 ms of each epoch while locked
      if (lock_3d && (epoch_q == EPOCH_CYC - 32'h0000_0001)) begin
        time_mark_out <= 1'b1;
        mark_led <= 1'b1;
      end else if (!lock_3d || epoch_q == MARK_CYC - 32'h0000_0001) begin
        time_mark_out <= 1'b0;
        mark_led <= 1'b0;
      end
    end
  end

  // Fix indicator: blink while searching, settle when locked
  always @(posedge clk_sys) begin
    if (reset) begin
      state_q <= ST_SEARCH;
      blink_q <= 32'h0000_0000;
      blink_lvl_q <= 1'b1;
      fix_status_n <= 1'b1;
      fix_led_n <= 1'b1;
    end else if (clk_en) begin
      case (state_q)
        ST_SEARCH: begin
          if (lock_3d) begin
            state_q <= ST_LOCKED;
            fix_status_n <= 1'b0;
            fix_led_n <= 1'b1;
          end else if (blink_q == BLINK_HALF_CYC - 32'h0000_0001) begin
            // Equal one-second halves give 0.5 Hz at 50/50
            blink_q <= 32'h0000_0000;
            blink_lvl_q <= ~blink_lvl_q;
            fix_status_n <= ~blink_lvl_q;
            fix_led_n <= ~blink_lvl_q;
          end else begin
            blink_q <= blink_q + 32'h0000_0001;
          end
        end
        ST_LOCKED: begin
          fix_status_n <= 1'b0;
          fix_led_n <= 1'b1;
          if (!lock_3d) begin
            // Lock lost: restart blink from a high half
            state_q <= ST_SEARCH;
            blink_q <= 32'h0000_0000;
            blink_lvl_q <= 1'b1;
            fix_status_n <= 1'b1;
          end
        end
        default: begin
          state_q <= ST_SEARCH;
        end
      endcase
    end
  end

  // Augmentation gate and factory-default request
  always @(posedge clk_sys) begin
    if (reset) begin
      aug_enable <= 1'b0;
      bat_q <= 32'h0000_0000;
      factory_default_req <= 1'b0;
    end else if (clk_en) begin
      aug_enable <= (update_hz <= 4'd`GFS_AUG_MAX_HZ);
      // Request latches until reset; defaults apply on next power-up
      if (backup_pin) begin
        bat_q <= 32'h0000_0000;
      end else if (bat_q != FACTORY_CYC) begin
        bat_q <= bat_q + 32'h0000_0001;
      end
      if (bat_q == FACTORY_CYC) begin
        factory_default_req <= 1'b1;
      end
    end
  end

  // Command receiver, samples mid-bit; correction_in is never read
  always @(posedge clk_sys) begin
    if (reset) begin
      rx_busy_q <= 1'b0;
      rx_baud_q <= 16'h0000;
      rx_bit_q <= 4'h0;
      rx_shift_q <= 8'h00;
      cmd_data <= 8'h00;
      cmd_valid <= 1'b0;
    end else if (clk_en) begin
      cmd_valid <= 1'b0;
      if (!rx_busy_q) begin
        if (!serial_rx) begin
          rx_busy_q <= 1'b1;
          rx_baud_q <= {1'b0, BIT_CYC[15:1]};
          rx_bit_q <= 4'd9;
        end
      end else if (rx_baud_q == 16'h0000) begin
        rx_baud_q <= BIT_CYC - 16'd1;
        rx_bit_q <= rx_bit_q - 4'd1;
        if (rx_bit_q == 4'd9) begin
          // False start bit is dropped
          if (serial_rx) begin
            rx_busy_q <= 1'b0;
          end
        end else if (rx_bit_q == 4'd0) begin
          rx_busy_q <= 1'b0;
          if (serial_rx) begin
            cmd_data <= rx_shift_q;
            cmd_valid <= 1'b1;
          end
        end else begin
          rx_shift_q <= {serial_rx, rx_shift_q[7:1]};
        end
      end else begin
        rx_baud_q <= rx_baud_q - 16'd1;
      end
    end
  end

  // Sentence transmitter; ready stays low while a frame is on the line
  // so the sentence source cannot overrun a byte in flight
  gfs_uart_tx #(
    .BIT_CYC(BIT_CYC)
  ) u_tx (
    .clk_sys(clk_sys),
    .reset(reset),
    .ce(clk_en),
    .tx_data(nmea_data),
    .tx_valid(nmea_valid),
    .tx_ready(nmea_ready),
    .tx_line(serial_tx)
  );
endmodule // gfs_fix_status

// [verilog/gfs_uart_tx.v]
`timescale 1ns/1ps
`include "gfs_defines.vh"
// Serial transmitter, 8 data bits, no parity, one stop bit, LSB first
module gfs_uart_tx #(
  parameter [15:0] BIT_CYC = `GFS_BIT_CYC
) (
  // Clock and reset
  clk_sys,
  reset,
  ce,
  // Byte stream in
  tx_data,
  tx_valid,
  tx_ready,
  // Line out
  tx_line
);
  input wire clk_sys;
  input wire reset;
  input wire ce;
  input wire [7:0] tx_data;
  input wire tx_valid;
  output reg tx_ready;
  output reg tx_line;

  reg [15:0] baud_q; // Cycles left in the current bit
  reg [3:0] bit_q; // Bits left in the frame
  reg [9:0] shift_q; // Stop, data, start

  // Frame shifter; ready only when idle so a byte is never overwritten
  always @(posedge clk_sys) begin
    if (reset) begin
      baud_q <= 16'h0000;
      bit_q <= 4'h0;
      shift_q <= 10'h3ff;
      tx_ready <= 1'b0;
      tx_line <= 1'b1;
    end else if (ce) begin
      if (bit_q == 4'h0) begin
        // Idle: line high, accept next byte
        tx_line <= 1'b1;
        tx_ready <= ~(tx_valid & tx_ready);
        if (tx_valid && tx_ready) begin
          shift_q <= {1'b1, tx_data, 1'b0};
          bit_q <= 4'd10;
          baud_q <= BIT_CYC - 16'd1;
          tx_line <= 1'b0;
          tx_ready <= 1'b0;
        end
      end else if (baud_q == 16'h0000) begin
        // Next bit, LSB first
        shift_q <= {1'b1, shift_q[9:1]};
        bit_q <= bit_q - 4'd1;
        baud_q <= BIT_CYC - 16'd1;
        tx_line <= (bit_q == 4'd1) ? 1'b1 : shift_q[1];
      end else begin
        baud_q <= baud_q - 16'd1;
      end
    end
  end
endmodule // gfs_uart_tx
